/* File: core/tlipc_core.sv */
// Two-level interrupt priority controller with vectoring and stack push
//
// Contract
// - Two vectors: high priority at 0008h, low priority at 0018h.
// - A high-priority request may preempt a running low-priority routine.
// - Every source has a flag, an enable and a priority select bit.
// - Priority-levels enable selects two-level mode; resets cleared (compatibility).
// - Compatibility mode ignores all priority select bits.
// - Compatibility: peripherals need peripheral and global enable; peripheral enable masks only them.
// - Compatibility: global enable allows core sources; cleared blocks everything.
// - Compatibility mode vectors every accepted interrupt to 0008h.
// - Priority mode: high global enable allows all high-priority sources.
// - Priority mode: high global enable cleared blocks all sources, low included.
// - Low sources need both low and high global enables set.
// - Flag, enable and level enable set: vector to 0008h or 0018h by priority.
// - Accepting an interrupt clears the global enable of its level.
// - No low-priority interrupt is taken during a high-priority routine.
// - Acceptance pushes the return address and loads the vector into PC.
// - Return from interrupt sets the serviced level's global enable again; a return in the same cycle as an acceptance is ignored.
// - Pin and port-change latency is three to four instruction cycles.
// - Flags set on events regardless of any enable, allowing polling.
// - High global enable is control bit 7, low is bit 6, reset 0.
module tlipc_core
   import tlipc_pkg::*;
(
   // Clock and reset
   input  wire logic              sys_clk_i,
   input  wire logic              rst_i,
   // Source events, one-cycle pulses
   input  wire logic [15:0]       src_event_i,
   // Software access to flags, enables and priority selects
   input  wire logic [15:0]       flag_clr_i,
   input  wire logic              enable_wr_i,
   input  wire logic [15:0]       enable_data_i,
   input  wire logic              prio_sel_wr_i,
   input  wire logic [15:0]       prio_sel_data_i,
   input  wire logic              ctrl_wr_i,
   input  wire logic [7:0]        ctrl_data_i,
   input  wire logic              prio_lvl_wr_i,
   input  wire logic              prio_lvl_data_i,
   // Core side
   input  wire logic              ret_intr_i,
   input  wire logic [20:0]       ret_pc_i,
   // Status
   output logic [15:0]            flags_o,
   output logic                   glob_hi_o,
   output logic                   glob_lo_o,
   output logic                   prio_lvl_o,
   output logic                   in_high_o,
   output logic                   in_low_o,
   // Vectoring to the core
   output logic                   pc_load_o,
   output logic [20:0]            pc_vector_o,
   output logic                   stack_push_o,
   output logic [20:0]            stack_data_o
);

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   // Any source whose flag, enable and selection bit are all set
   function automatic logic any_armed(input logic [15:0] flg, input logic [15:0] en,
                                      input logic [15:0] sel);
      any_armed = |(flg & en & sel);
   endfunction : any_armed

   logic [15:0]  flag_q;
   logic [15:0]  enable_q;
   logic [15:0]  prio_sel_q;
   logic         glob_hi_q;
   logic         glob_lo_q;
   logic         prio_lvl_q;
   logic         in_high_q;
   logic         in_low_q;
   logic [1:0]   tcy_cnt_q;
   logic         tcy_q;
   logic [1:0]   ack_cnt_q;
   tlipc_state_e st_q;
   logic         req_hi;
   logic         req_lo;
   logic         req_any;
   logic         take;

   // ------------------------------------------------------------------
   // Instruction-cycle enable: one pulse every four clocks
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         tcy_cnt_q <= 2'h0;
         tcy_q     <= 1'b0;
      end else begin
         tcy_cnt_q <= (tcy_cnt_q == TCY_LAST) ? 2'h0 : tcy_cnt_q + 2'h1;
         tcy_q     <= (tcy_cnt_q == TCY_LAST);
      end
   end

   // ------------------------------------------------------------------
   // Request flags: a new event beats a software clear in the same cycle
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         flag_q <= 16'h0000;
      end else begin
         flag_q <= (flag_q & ~flag_clr_i) | src_event_i;
      end
   end

   // Per-source enables and priority selects, written by software
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         enable_q   <= ENABLE_RST;
         prio_sel_q <= PRIO_SEL_RST;
      end else begin
         if (enable_wr_i) begin
            enable_q <= enable_data_i;
         end
         if (prio_sel_wr_i) begin
            prio_sel_q <= prio_sel_data_i;
         end
      end
   end

   // Mode select, cleared at reset so compatibility mode is the default
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         prio_lvl_q <= PRIO_LVL_RST;
      end else if (prio_lvl_wr_i) begin
         prio_lvl_q <= prio_lvl_data_i;
      end
   end

   // ------------------------------------------------------------------
   // Request qualification
   // ------------------------------------------------------------------
   // Compatibility mode ignores priority selects and routes everything high
   always_comb begin
      if (!prio_lvl_q) begin
         req_hi = glob_hi_q & (any_armed(flag_q, enable_q, ~PERIPH_MASK)
                  | (glob_lo_q & any_armed(flag_q, enable_q, PERIPH_MASK)));
         req_lo = 1'b0;
      end else begin
         req_hi = glob_hi_q & any_armed(flag_q, enable_q, prio_sel_q);
         // High routine in progress also keeps low requests out
         req_lo = glob_hi_q & glob_lo_q & ~in_high_q
                  & any_armed(flag_q, enable_q, ~prio_sel_q);
      end
   end
   assign req_any = req_hi | req_lo;

   // ------------------------------------------------------------------
   // Acceptance sequencer: sighting at one boundary, vector three later
   // ------------------------------------------------------------------
   assign take = (st_q == TLIPC_WAIT) && tcy_q && req_any
                 && (ack_cnt_q == ACK_TCY - 2'h1);

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_q      <= TLIPC_IDLE;
         ack_cnt_q <= 2'h0;
      end else begin
         case (st_q)
            TLIPC_IDLE: begin
               if (tcy_q && req_any) begin
                  st_q      <= TLIPC_WAIT;
                  ack_cnt_q <= 2'h0;
               end
            end
            TLIPC_WAIT: begin
               // A withdrawn request is dropped, so polling software wins
               if (tcy_q) begin
                  if (!req_any || take) begin
                     st_q <= TLIPC_IDLE;
                  end
                  ack_cnt_q <= ack_cnt_q + 2'h1;
               end
            end
            default: begin
               st_q <= TLIPC_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Global enables: entry clears, return sets, software otherwise
   // ------------------------------------------------------------------
   // Hardware entry beats a software write so a level cannot reenter
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         glob_hi_q <= GLOB_RST;
         glob_lo_q <= GLOB_RST;
      end else if (take) begin
         if (req_hi) begin
            glob_hi_q <= 1'b0;
         end else begin
            glob_lo_q <= 1'b0;
         end
      end else if (ret_intr_i) begin
         if (!prio_lvl_q || in_high_q) begin
            glob_hi_q <= 1'b1;
         end else begin
            glob_lo_q <= 1'b1;
         end
      end else if (ctrl_wr_i) begin
         glob_hi_q <= ctrl_data_i[CTRL_HI_BIT];
         glob_lo_q <= ctrl_data_i[CTRL_LO_BIT];
      end
   end

   // Routine tracking: a high entry may nest over a low routine
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         in_high_q <= 1'b0;
         in_low_q  <= 1'b0;
      end else if (take) begin
         if (req_hi) begin
            in_high_q <= 1'b1;
         end else begin
            in_low_q  <= 1'b1;
         end
      end else if (ret_intr_i) begin
         if (in_high_q) begin
            in_high_q <= 1'b0;
         end else begin
            in_low_q  <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------
   // Vector and stack push toward the core, one-cycle pulses
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pc_load_o    <= 1'b0;
         stack_push_o <= 1'b0;
         pc_vector_o  <= VEC_HIGH;
         stack_data_o <= 21'h000000;
      end else begin
         pc_load_o    <= take;
         stack_push_o <= take;
         if (take) begin
            // High wins when both levels are ready at once
            pc_vector_o  <= req_hi ? VEC_HIGH : VEC_LOW;
            stack_data_o <= ret_pc_i;
         end
      end
   end

   // Status outputs straight from flops
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         flags_o    <= 16'h0000;
         glob_hi_o  <= GLOB_RST;
         glob_lo_o  <= GLOB_RST;
         prio_lvl_o <= PRIO_LVL_RST;
         in_high_o  <= 1'b0;
         in_low_o   <= 1'b0;
      end else begin
         flags_o    <= flag_q;
         glob_hi_o  <= glob_hi_q;
         glob_lo_o  <= glob_lo_q;
         prio_lvl_o <= prio_lvl_q;
         in_high_o  <= in_high_q;
         in_low_o   <= in_low_q;
      end
   end

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   sequence wait_seen_s;
      st_q == TLIPC_IDLE && tcy_q && req_any;
   endsequence
   // Nothing may withdraw or reshape the request while the count runs
   sequence req_held_s;
      req_any && !ret_intr_i && !ctrl_wr_i && !enable_wr_i && flag_clr_i == 16'h0000
      && !prio_lvl_wr_i && !prio_sel_wr_i;
   endsequence
   sequence vector_out_s;
      ##1 pc_load_o;
   endsequence

   vector_range_a: assert property (pc_load_o |->
      (pc_vector_o == VEC_HIGH || pc_vector_o == VEC_LOW))
      else $error("vector address is neither high nor low");
   compat_vector_a: assert property (take && !prio_lvl_q |=>
      pc_vector_o == VEC_HIGH)
      else $error("compatibility mode vectored to the low address");
   entry_clear_a: assert property (take && req_hi |=> !glob_hi_q)
      else $error("high level enable not cleared on entry");
   low_blocked_a: assert property (in_high_q |-> !(take && !req_hi))
      else $error("low interrupt taken inside a high routine");
   flag_set_a: assert property (src_event_i != 16'h0000 |=>
      (flag_q & $past(src_event_i)) == $past(src_event_i))
      else $error("event did not set its flag");
   return_set_a: assert property (ret_intr_i && !take && !prio_lvl_q |=>
      glob_hi_q)
      else $error("return did not restore the global enable");
   enable_gate_a: assert property (pc_load_o |-> $past(glob_hi_q))
      else $error("interrupt accepted with high global enable cleared");
   latency_a: assert property (wait_seen_s ##1 req_held_s [*8]
      ##1 req_held_s [*4] |-> vector_out_s)
      else $error("vector not issued three instruction cycles after sighting");
   high_first_a: assert property (take && req_hi && req_lo |=>
      pc_vector_o == VEC_HIGH)
      else $error("low request served ahead of high");
   push_pair_a: assert property (pc_load_o |-> stack_push_o
      && stack_data_o == $past(ret_pc_i))
      else $error("vector load without matching stack push");

endmodule : tlipc_core

/* File: inc/tlipc_pkg.sv */
// Constants shared by the two-level interrupt priority controller
package tlipc_pkg;
   // ------------------------------------------------------------------
   // Sources and vectors
   // ------------------------------------------------------------------
   localparam int          NUM_SRC  = 16;
   localparam int          PC_W     = 21;
   // Bit set marks a peripheral source, clear a core source
   localparam logic [15:0] PERIPH_MASK = 16'hFF00;
   localparam logic [20:0] VEC_HIGH = 21'h000008;
   localparam logic [20:0] VEC_LOW  = 21'h000018;
   // ------------------------------------------------------------------
   // Main interrupt control byte layout and reset values
   // ------------------------------------------------------------------
   localparam int          CTRL_HI_BIT   = 7;
   localparam int          CTRL_LO_BIT   = 6;
   localparam logic        GLOB_RST      = 1'b0;
   localparam logic        PRIO_LVL_RST  = 1'b0;
   localparam logic [15:0] ENABLE_RST    = 16'h0000;
   localparam logic [15:0] PRIO_SEL_RST  = 16'hFFFF;
   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int          CLK_MHZ       = 100;
   localparam int          CLK_PER_TCY   = 4;
   localparam logic [1:0]  TCY_LAST      = 2'(CLK_PER_TCY - 1);
   // Instruction cycles from first sighting of a request to the vector
   localparam logic [1:0]  ACK_TCY       = 2'h3;
   typedef enum logic [1:0] {
      TLIPC_IDLE = 2'b00,
      TLIPC_WAIT = 2'b01
   } tlipc_state_e;
endpackage : tlipc_pkg

/* File: dv/tlipc_cpu_model.sv */
// Processor core stand-in: return stack, return address and return strobe
module tlipc_cpu_model (
   // Clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        rst_i,
   // Vectoring from the controller
   input  wire logic        pc_load_i,
   input  wire logic [20:0] pc_vector_i,
   input  wire logic        stack_push_i,
   input  wire logic [20:0] stack_data_i,
   // Return request from the bench, return and address to the controller
   input  wire logic        ret_req_i,
   output logic             ret_intr_o,
   output logic [20:0]      ret_pc_o,
   output logic [7:0]       push_err_o,
   output logic [3:0]       depth_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [20:0] stack_q [$];
   // ---------------------------------------------------------------
   // Stack and program counter
   // ---------------------------------------------------------------
   // The address in hand sits still while a request waits, so any push
   // of a stale or wrong address is caught exactly
   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         stack_q.delete();
         ret_intr_o <= 1'b0;
         ret_pc_o   <= 21'h000100;
         push_err_o <= 8'h00;
         depth_o    <= 4'h0;
      end else begin
         ret_intr_o <= ret_req_i;
         if ((stack_push_i !== pc_load_i) || (pc_load_i && stack_data_i !== ret_pc_o)) begin
            push_err_o <= push_err_o + 8'h01;
         end
         if (pc_load_i) begin
            stack_q.push_back(stack_data_i);
            depth_o  <= depth_o + 4'h1;
            ret_pc_o <= pc_vector_i + 21'h000002; // Now inside the routine
         end else if (ret_req_i && stack_q.size() > 0) begin
            ret_pc_o <= stack_q.pop_back();
            depth_o  <= depth_o - 4'h1;
         end
      end
   end
endmodule : tlipc_cpu_model

/* File: dv/tb_two_level_interrupt_priority_controller.sv */
// Self-checking bench for the two-level interrupt priority controller
module tb_two_level_interrupt_priority_controller;
   timeunit 1ns;
   timeprecision 100ps;
   import tlipc_pkg::*;
   typedef struct packed {
      logic lvl; logic [7:0] ctrl; logic en; logic sel; logic [3:0] idx; logic take;
      logic [20:0] vec;
   } tlipc_row_s;
   logic        sys_clk_i, rst_i, enable_wr_i, prio_sel_wr_i, ctrl_wr_i, prio_lvl_wr_i;
   logic        prio_lvl_data_i, ret_intr_i, glob_hi_o, glob_lo_o, prio_lvl_o;
   logic        in_high_o, in_low_o, pc_load_o, stack_push_o, ret_req;
   logic [15:0] src_event_i, flag_clr_i, enable_data_i, prio_sel_data_i, flags_o;
   logic [7:0]  ctrl_data_i, push_err;
   logic [20:0] ret_pc_i, pc_vector_o, stack_data_o;
   logic [3:0]  depth;
   int          miscompares, check_count, n;
   // Mode, control byte, enable, priority select, source, taken, vector
   tlipc_row_s rows [11] = '{
      '{1'b0, 8'hC0, 1'b1, 1'b0, 4'h0, 1'b1, VEC_HIGH},
      '{1'b0, 8'h80, 1'b1, 1'b1, 4'h1, 1'b1, VEC_HIGH},
      '{1'b0, 8'h80, 1'b1, 1'b1, 4'h9, 1'b0, VEC_HIGH},
      '{1'b0, 8'hC0, 1'b1, 1'b0, 4'h9, 1'b1, VEC_HIGH},
      '{1'b0, 8'h40, 1'b1, 1'b1, 4'h2, 1'b0, VEC_HIGH},
      '{1'b1, 8'h80, 1'b1, 1'b1, 4'h3, 1'b1, VEC_HIGH},
      '{1'b1, 8'h40, 1'b1, 1'b0, 4'h4, 1'b0, VEC_HIGH},
      '{1'b1, 8'h80, 1'b1, 1'b0, 4'hA, 1'b0, VEC_HIGH},
      '{1'b1, 8'hC0, 1'b1, 1'b0, 4'hA, 1'b1, VEC_LOW},
      '{1'b1, 8'h40, 1'b1, 1'b1, 4'h5, 1'b0, VEC_HIGH},
      '{1'b1, 8'hC0, 1'b0, 1'b1, 4'h6, 1'b0, VEC_HIGH}
   };
   tlipc_core dut_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .src_event_i(src_event_i),
      .flag_clr_i(flag_clr_i), .enable_wr_i(enable_wr_i), .enable_data_i(enable_data_i),
      .prio_sel_wr_i(prio_sel_wr_i), .prio_sel_data_i(prio_sel_data_i),
      .ctrl_wr_i(ctrl_wr_i), .ctrl_data_i(ctrl_data_i), .prio_lvl_wr_i(prio_lvl_wr_i),
      .prio_lvl_data_i(prio_lvl_data_i), .ret_intr_i(ret_intr_i), .ret_pc_i(ret_pc_i),
      .flags_o(flags_o), .glob_hi_o(glob_hi_o), .glob_lo_o(glob_lo_o),
      .prio_lvl_o(prio_lvl_o), .in_high_o(in_high_o), .in_low_o(in_low_o),
      .pc_load_o(pc_load_o), .pc_vector_o(pc_vector_o), .stack_push_o(stack_push_o),
      .stack_data_o(stack_data_o));
   tlipc_cpu_model core_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .pc_load_i(pc_load_o),
      .pc_vector_i(pc_vector_o), .stack_push_i(stack_push_o), .stack_data_i(stack_data_o),
      .ret_req_i(ret_req), .ret_intr_o(ret_intr_i), .ret_pc_o(ret_pc_i),
      .push_err_o(push_err), .depth_o(depth));
   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   // Inputs always move 1 ns after an edge, never on it
   task automatic tick(input int k);
      repeat (k) @(posedge sys_clk_i);
      #1;
   endtask : tick
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic do_reset();
      rst_i = 1'b1;
      tick(4);
      rst_i = 1'b0;
      tick(1);
   endtask : do_reset
   // All four writes land in one cycle; outputs follow two edges later
   // Control is written as one strobed word, never by a memory-to-memory copy
   task automatic cfg(input logic lvl, input logic [7:0] c, input logic [15:0] e,
                      input logic [15:0] s);
      {prio_lvl_wr_i, ctrl_wr_i, enable_wr_i, prio_sel_wr_i} = 4'hF;
      prio_lvl_data_i = lvl;
      ctrl_data_i = c;
      enable_data_i = e;
      prio_sel_data_i = s;
      tick(1);
      {prio_lvl_wr_i, ctrl_wr_i, enable_wr_i, prio_sel_wr_i} = 4'h0;
      tick(2);
   endtask : cfg
   task automatic pulse(input logic [15:0] ev, input logic [15:0] clr);
      src_event_i = ev;
      flag_clr_i = clr;
      tick(1);
      src_event_i = 16'h0000;
      flag_clr_i = 16'h0000;
   endtask : pulse
   // Bounded wait; k stays 0 if nothing is vectored in time
   task automatic wait_load(input int lim, output int k);
      k = 0;
      for (int i = 1; i <= lim && k == 0; i++) begin
         tick(1);
         if (pc_load_o === 1'b1) k = i;
      end
   endtask : wait_load
   task automatic do_ret();
      ret_req = 1'b1;
      tick(1);
      ret_req = 1'b0;
      tick(2);
   endtask : do_ret
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : tally_and_finish
   // ---------------------------------------------------------------
   // Clock, watchdog and main sequence
   // ---------------------------------------------------------------
   initial begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   initial begin
      #200us;
      miscompares++;
      tally_and_finish();
   end
   initial begin
      {enable_wr_i, prio_sel_wr_i, ctrl_wr_i, prio_lvl_wr_i, prio_lvl_data_i, ret_req} = '0;
      {src_event_i, flag_clr_i, enable_data_i, prio_sel_data_i, ctrl_data_i} = '0;
      miscompares = 0;
      check_count = 0;
      do_reset();
      chk("glob_hi reset", glob_hi_o, GLOB_RST);
      chk("glob_lo reset", glob_lo_o, GLOB_RST);
      chk("mode reset", prio_lvl_o, PRIO_LVL_RST);
      chk("vector reset", pc_vector_o, VEC_HIGH);
      cfg(1'b1, 8'h80, 16'h0000, 16'h0000);
      chk("bit7 only", {prio_lvl_o, glob_hi_o, glob_lo_o}, 3'b110);
      foreach (rows[r]) begin
         do_reset();
         cfg(rows[r].lvl, rows[r].ctrl, 16'(rows[r].en) << rows[r].idx, {16{rows[r].sel}});
         pulse(16'h0001 << rows[r].idx, 16'h0000);
         wait_load(24, n);
         chk("taken", n != 0, rows[r].take);
         chk("flag set", flags_o[rows[r].idx], 1'b1);
         if (rows[r].take) begin
            chk("latency", n >= 13 && n <= 17, 1'b1);
            chk("vector", pc_vector_o, rows[r].vec);
            tick(1);
            chk("level off", rows[r].vec == VEC_HIGH ? glob_hi_o : glob_lo_o, 1'b0);
            chk("row push errors", push_err, 8'h00);
         end
      end
      // High and low raised together, then nesting and returns
      do_reset();
      cfg(1'b1, 8'hC0, 16'h0408, 16'h0008);
      pulse(16'h0408, 16'h0000);
      wait_load(24, n);
      chk("high first", pc_vector_o, VEC_HIGH);
      pulse(16'h0000, 16'h0008);
      cfg(1'b1, 8'hC0, 16'h0408, 16'h0008);
      wait_load(24, n);
      chk("low held off", n, 0);
      do_ret();
      wait_load(24, n);
      chk("low after return", pc_vector_o, VEC_LOW);
      pulse(16'h0008, 16'h0000);
      wait_load(24, n);
      chk("preempt", pc_vector_o, VEC_HIGH);
      // The model counts the push one edge after the load pulse shows
      tick(1);
      chk("depth", depth, 4'h2);
      chk("low still open", in_low_o, 1'b1);
      pulse(16'h0000, 16'h0008);
      do_ret();
      chk("high back on", {glob_hi_o, in_high_o}, 2'b10);
      pulse(16'h0000, 16'h0400);
      do_ret();
      chk("low back on", {glob_lo_o, in_low_o}, 2'b10);
      wait_load(24, n);
      chk("no repeat", n, 0);
      chk("push errors", push_err, 8'h00);
      tally_and_finish();
   end
endmodule : tb_two_level_interrupt_priority_controller
